// *** logic/frf_pkg.sv ***
// Purpose: Shared constants and types for the FPU result forwarding block.
// Assumes: One core clock, synchronous active-high reset.
// Notes: Opcode and destination codes are local encodings of this block.
package frf_pkg;
  localparam int unsigned FRF_DATA_W = 32;
  localparam int unsigned FRF_REG_W = 3;
  localparam int unsigned FRF_EXEC_STAGES = 3;
  localparam logic [31:0] FRF_RESULT_RESET = 32'h0000_0000;
  typedef enum logic [2:0] {
    FRF_OP_NONE = 3'h0,
    FRF_OP_MPY = 3'h1,
    FRF_OP_ADD = 3'h2,
    FRF_OP_SUB = 3'h3,
    FRF_OP_MAC = 3'h4,
    FRF_OP_OTHER = 3'h5
  } frf_op_type;
  typedef enum logic [1:0] {
    FRF_DST_NONE = 2'h0,
    FRF_DST_CPU = 2'h1,
    FRF_DST_FPU = 2'h2
  } frf_dst_type;
endpackage : frf_pkg

// *** logic/frf_exec_pipe.sv ***
// Purpose: Three-phase execute pipe of a two-cycle FPU producer.
// Assumes: Stall holds every phase in place.
// Notes: Result becomes valid leaving the second phase, in the third.
`timescale 1ns/100ps
`default_nettype none
module frf_exec_pipe #(
  parameter int unsigned DATA_W = 32,
  parameter int unsigned REG_W = 3
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Issue side.
  input wire logic issue,
  input wire logic [REG_W-1:0] issue_dst,
  input wire logic [DATA_W-1:0] issue_value,
  input wire logic stall,
  // Phase state.
  output logic [2:0] phase_valid,
  output logic [REG_W-1:0] phase_dst [3],
  output logic [DATA_W-1:0] third_value
);
  import frf_pkg::*;
  if (DATA_W < 1 || REG_W < 1) begin : g_bad_width
    $error("frf_exec_pipe: bad width");
  end
  logic [2:0] next_phase_valid;
  logic [REG_W-1:0] next_phase_dst [3];
  logic [DATA_W-1:0] stage_value [2];
  logic [DATA_W-1:0] next_stage_value [2];
  logic [DATA_W-1:0] next_third_value;

  always_comb begin
    next_phase_valid = phase_valid;
    next_phase_dst = phase_dst;
    next_stage_value = stage_value;
    next_third_value = third_value;
    if (!stall) begin
      next_phase_valid = {phase_valid[1:0], issue};
      next_phase_dst = '{issue_dst, phase_dst[0], phase_dst[1]};
      next_stage_value = '{issue_value, stage_value[0]};
      next_third_value = stage_value[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      phase_valid <= 3'h0;
      phase_dst <= '{default: '0};
      stage_value <= '{default: '0};
      third_value <= DATA_W'(FRF_RESULT_RESET);
    end else begin
      phase_valid <= next_phase_valid;
      phase_dst <= next_phase_dst;
      stage_value <= next_stage_value;
      third_value <= next_third_value;
    end
  end
endmodule : frf_exec_pipe
`default_nettype wire

// *** logic/frf_forward.sv ***
// Purpose: Forwarding and hazard control from two-cycle FPU producers to moves.
// Assumes: Producer values arrive with issue; the move waits at its read phase.
// Notes: Moves to CPU registers are held until any matching producer reaches the third execute phase.
// Notes on behaviour
// - A two-cycle result is forwarded from the third execute phase before the register file holds it.
// - A stall of the producer in the third execute phase still delivers the new value to the move.
// - The hazard exists only when the move source equals a pending two-cycle destination.
// - Only multiply, add, subtract and multiply-accumulate are two-cycle producers here.
// - The affected move has a CPU destination such as accumulator or auxiliary registers.
// - A move between FPU registers always reads the register file value at once, even while a producer to its source is pending.
// - The move samples its source as it enters the second read phase.
// - A read three cycles after the producer sees the result through forwarding.
`timescale 1ns/100ps
`default_nettype none
module frf_forward #(
  parameter int unsigned DATA_W = frf_pkg::FRF_DATA_W,
  parameter int unsigned REG_W = frf_pkg::FRF_REG_W
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Producer issue.
  input wire frf_pkg::frf_op_type prod_op,
  input wire logic [REG_W-1:0] prod_dst,
  input wire logic [DATA_W-1:0] prod_value,
  input wire logic prod_stall,
  // Move at second read phase.
  input wire logic move_enter,
  input wire frf_pkg::frf_dst_type move_dst,
  input wire logic [REG_W-1:0] move_src,
  // Register file read port.
  output logic [REG_W-1:0] rf_read_addr,
  input wire logic [DATA_W-1:0] rf_read_data,
  // Register file write port.
  output logic rf_write,
  output logic [REG_W-1:0] rf_write_addr,
  output logic [DATA_W-1:0] rf_write_data,
  // Move operand.
  output logic move_hold,
  output logic operand_valid,
  output logic [DATA_W-1:0] operand
);
  import frf_pkg::*;
  if (DATA_W < 1 || REG_W < 1) begin : g_bad_width
    $error("frf_forward: bad width");
  end

  logic two_cycle_issue;
  logic [2:0] phase_valid;
  logic [REG_W-1:0] phase_dst [3];
  logic [DATA_W-1:0] third_value;
  logic [2:0] match;
  logic cpu_move;
  logic next_operand_valid;
  logic [DATA_W-1:0] next_operand;

  assign two_cycle_issue = (prod_op == FRF_OP_MPY) || (prod_op == FRF_OP_ADD) ||
                           (prod_op == FRF_OP_SUB) || (prod_op == FRF_OP_MAC);

  frf_exec_pipe #(.DATA_W(DATA_W), .REG_W(REG_W)) u_pipe (
    .mclk(mclk),
    .rst(rst),
    .issue(two_cycle_issue),
    .issue_dst(prod_dst),
    .issue_value(prod_value),
    .stall(prod_stall),
    .phase_valid(phase_valid),
    .phase_dst(phase_dst),
    .third_value(third_value)
  );

  assign rf_write = phase_valid[2] && !prod_stall;
  assign rf_write_addr = phase_dst[2];
  assign rf_write_data = third_value;
  assign rf_read_addr = move_src;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_match
      assign match[gi] = phase_valid[gi] && (phase_dst[gi] == move_src);
    end
  endgenerate

  assign cpu_move = move_enter && (move_dst == FRF_DST_CPU);
  assign move_hold = cpu_move && (match[0] || match[1]);

  always_comb begin
    next_operand_valid = 1'b0;
    next_operand = operand;
    if (move_enter && !move_hold) begin
      next_operand_valid = 1'b1;
      if (cpu_move && match[2]) begin
        next_operand = third_value;
      end else begin
        next_operand = rf_read_data;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      operand_valid <= 1'b0;
      operand <= DATA_W'(FRF_RESULT_RESET);
    end else begin
      operand_valid <= next_operand_valid;
      operand <= next_operand;
    end
  end


  a_stall_forward: assert property (@(posedge mclk) disable iff (rst)
    cpu_move && match[2] && !match[1] && !match[0] |=> operand_valid && operand == $past(third_value))
    else $error("stalled forward lost");
  a_stall_keeps_result: assert property (@(posedge mclk) disable iff (rst)
    prod_stall && phase_valid[2] |=> phase_valid[2] && third_value == $past(third_value))
    else $error("stalled result moved");
  a_write_after_freeze: assert property (@(posedge mclk) disable iff (rst)
    prod_stall && phase_valid[2] ##1 !prod_stall |-> rf_write)
    else $error("no retire after stall");
  a_hold_pending: assert property (@(posedge mclk) disable iff (rst)
    cpu_move && ((phase_valid[0] && phase_dst[0] == move_src) ||
    (phase_valid[1] && phase_dst[1] == move_src)) |-> move_hold)
    else $error("move not held");
  a_take_after_hold: assert property (@(posedge mclk) disable iff (rst)
    move_enter && !move_hold |=> operand_valid)
    else $error("taken move not sampled");
  a_hold_no_sample: assert property (@(posedge mclk) disable iff (rst)
    move_hold |=> !operand_valid)
    else $error("sample while held");
  a_valid_from_take: assert property (@(posedge mclk) disable iff (rst)
    operand_valid |-> $past(move_enter && !move_hold))
    else $error("sample without move");
  a_operand_kept: assert property (@(posedge mclk) disable iff (rst)
    !(move_enter && !move_hold) |=> $stable(operand))
    else $error("operand changed idle");
  a_fpu_move_free: assert property (@(posedge mclk) disable iff (rst)
    move_enter && move_dst != FRF_DST_CPU |-> !move_hold ##1 operand == $past(rf_read_data))
    else $error("fpu move wrong");
  a_only_four_ops: assert property (@(posedge mclk) disable iff (rst)
    !prod_stall && prod_op == FRF_OP_OTHER |=> !phase_valid[0])
    else $error("wrong producer class");
  a_issue_enters: assert property (@(posedge mclk) disable iff (rst)
    two_cycle_issue && !prod_stall |=> phase_valid[0] && phase_dst[0] == $past(prod_dst))
    else $error("producer not taken");
  a_retire_write: assert property (@(posedge mclk) disable iff (rst)
    two_cycle_issue && !prod_stall ##1 !prod_stall [*3] |-> rf_write)
    else $error("no retire write");
  a_pipe_advance: assert property (@(posedge mclk) disable iff (rst)
    !prod_stall && phase_valid[1] |=> phase_valid[2])
    else $error("pipe did not advance");
  a_write_not_stalled: assert property (@(posedge mclk) disable iff (rst)
    prod_stall |-> !rf_write)
    else $error("write during stall");
  a_no_match_read: assert property (@(posedge mclk) disable iff (rst)
    move_enter && match == 3'h0 |=> operand == $past(rf_read_data))
    else $error("spurious forward");
  a_hold_needs_match: assert property (@(posedge mclk) disable iff (rst)
    move_hold |-> (phase_valid[0] && phase_dst[0] == move_src) ||
    (phase_valid[1] && phase_dst[1] == move_src))
    else $error("hold without match");
  a_cpu_only_hold: assert property (@(posedge mclk) disable iff (rst)
    move_hold |-> move_enter && move_dst == FRF_DST_CPU)
    else $error("non cpu move held");
  a_hold_bounded: assert property (@(posedge mclk) disable iff (rst)
    move_hold && !prod_stall && !two_cycle_issue ##1 move_hold && !prod_stall && !two_cycle_issue |=> !move_hold)
    else $error("hold too long");
  a_result_third: assert property (@(posedge mclk) disable iff (rst)
    two_cycle_issue && !prod_stall ##1 !prod_stall [*2] |=> third_value == $past(prod_value, FRF_EXEC_STAGES))
    else $error("result not in third phase");

  c_stall_forward: cover property (@(posedge mclk) disable iff (rst) cpu_move && match[2] && prod_stall);
  c_hold: cover property (@(posedge mclk) disable iff (rst) move_hold);
  c_fpu_move: cover property (@(posedge mclk) disable iff (rst) move_enter && move_dst == FRF_DST_FPU);
  c_retire: cover property (@(posedge mclk) disable iff (rst) rf_write);
  c_spaced_read: cover property (@(posedge mclk) disable iff (rst) cpu_move && !move_hold && match == 3'h0);
endmodule : frf_forward
`default_nettype wire

// *** tb/tb_frf_forward.sv ***
// Purpose: Self-checking bench for the FPU result forwarding block.
// Assumes: Inputs change at the rising edge by non-blocking assignment.
// Notes: Register file data is driven as a stale value distinct from the forwarded one.
`timescale 1ns/100ps
`default_nettype none
module tb_frf_forward;
  import frf_pkg::*;
  logic mclk, rst, prod_stall, move_enter, rf_write, move_hold, operand_valid;
  frf_op_type prod_op;
  frf_dst_type move_dst;
  logic [FRF_REG_W-1:0] prod_dst, move_src, rf_read_addr, rf_write_addr;
  logic [FRF_DATA_W-1:0] prod_value, rf_read_data, rf_write_data, operand;
  int failures, n_checks;
  frf_forward u_dut (.mclk(mclk), .rst(rst), .prod_op(prod_op), .prod_dst(prod_dst), .prod_value(prod_value),
    .prod_stall(prod_stall), .move_enter(move_enter), .move_dst(move_dst), .move_src(move_src),
    .rf_read_addr(rf_read_addr), .rf_read_data(rf_read_data), .rf_write(rf_write),
    .rf_write_addr(rf_write_addr), .rf_write_data(rf_write_data), .move_hold(move_hold),
    .operand_valid(operand_valid), .operand(operand));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [FRF_DATA_W-1:0] seen, input logic [FRF_DATA_W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  task automatic issue(input frf_op_type op, input logic [FRF_DATA_W-1:0] v);
    @(posedge mclk);
    prod_op <= op;
    prod_dst <= 3'h6;
    prod_value <= v;
    rf_read_data <= ~v;
    @(posedge mclk);
    prod_op <= FRF_OP_NONE;
  endtask : issue
  // A dependent CPU move is held until the producer reaches phase three.
  task automatic dependent_move(input frf_op_type op, input logic stall, input logic [FRF_DATA_W-1:0] v);
    issue(op, v);
    move_enter <= 1'b1;
    move_dst <= FRF_DST_CPU;
    move_src <= 3'h6;
    #1 check(move_hold, 1'b1);
    check(rf_read_addr, 3'h6);
    @(posedge mclk);
    #1 check(move_hold, 1'b1);
    @(posedge mclk);
    prod_stall <= stall;
    #1 check(move_hold, 1'b0);
    check(rf_write, !stall);
    @(posedge mclk);
    move_enter <= 1'b0;
    prod_stall <= 1'b0;
    #1 check(operand_valid, 1'b1);
    check(operand, v);
    check(rf_write, stall);
    check(rf_write_data, v);
    check(rf_write_addr, 3'h6);
    @(posedge mclk);
    #1 check(operand_valid, 1'b0);
    check(rf_write, 1'b0);
  endtask : dependent_move
  // four-slot spacing: the move enters after retirement and reads the updated register.
  task automatic spaced_move(input logic [FRF_DATA_W-1:0] v);
    issue(FRF_OP_MAC, v);
    repeat (2) @(posedge mclk);
    #1 check(rf_write, 1'b1);
    @(posedge mclk);
    rf_read_data <= v;
    move_enter <= 1'b1;
    move_dst <= FRF_DST_CPU;
    move_src <= 3'h6;
    #1 check(move_hold, 1'b0);
    @(posedge mclk);
    move_enter <= 1'b0;
    #1 check(operand_valid, 1'b1);
    check(operand, v);
  endtask : spaced_move
  // A move that is not a CPU move from a pending two-cycle destination is taken at once from the register file.
  task automatic free_move(input frf_op_type op, input frf_dst_type dst, input logic [2:0] src);
    issue(op, 32'h4040_0000);
    move_enter <= 1'b1;
    move_dst <= dst;
    move_src <= src;
    #1 check(move_hold, 1'b0);
    @(posedge mclk);
    move_enter <= 1'b0;
    #1 check(operand_valid, 1'b1);
    check(operand, 32'hbfbf_ffff);
    repeat (3) @(posedge mclk);
  endtask : free_move
  initial begin
    rst = 1'b1;
    prod_op = FRF_OP_NONE;
    prod_dst = 3'h0;
    prod_value = 32'h0;
    prod_stall = 1'b0;
    move_enter = 1'b0;
    move_dst = FRF_DST_NONE;
    move_src = 3'h0;
    rf_read_data = 32'h0;
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    #1 check(operand_valid, 1'b0);
    check(operand, FRF_RESULT_RESET);
    check(rf_write, 1'b0);
    dependent_move(FRF_OP_MPY, 1'b0, 32'h3f80_0001);
    dependent_move(FRF_OP_ADD, 1'b0, 32'h3f80_0002);
    dependent_move(FRF_OP_SUB, 1'b1, 32'h3f80_0003);
    dependent_move(FRF_OP_MAC, 1'b1, 32'h3f80_0004);
    spaced_move(32'h3f80_0005);
    free_move(FRF_OP_MPY, FRF_DST_FPU, 3'h6);
    free_move(FRF_OP_ADD, FRF_DST_CPU, 3'h5);
    free_move(FRF_OP_OTHER, FRF_DST_CPU, 3'h6);
    tally_and_finish();
  end
  initial begin
    #(40 * 2000);
    failures++;
    tally_and_finish();
  end
endmodule : tb_frf_forward
`default_nettype wire
